//--- sim/sga_ability_regs_sva.sv
// Checker for the line-side outputs of the SGMII ability register bank.
// Assumes it is bound onto sga_ability_regs; one clock domain only.
`timescale 1ns/1ps
module sga_ability_regs_sva (
    // Clock and clearing sources
    input wire        i_clk,
    input wire        i_rst_n,
    input wire        i_clk_locked,
    input wire        i_soft_rst,
    input wire        i_phy_mode,
    // Configuration and line events
    input wire        i_cfg_valid,
    input wire [15:0] i_cfg_adv,
    input wire        i_page_valid,
    input wire [15:0] i_page_word,
    input wire        i_np_sent,
    // Outputs watched
    input wire [15:0] o_adv_word,
    input wire [15:0] o_np_word,
    input wire        o_partner_link_up,
    input wire        o_partner_full_duplex,
    input wire [1:0]  o_partner_speed,
    input wire        o_page_received
);
    // Clearing sources other than the main reset, and decoded views
    wire        ok       = i_clk_locked && !i_soft_rst;
    wire [15:0] adv_rsvd = o_adv_word & 16'h23FE;
    wire [3:0]  dec      = {o_partner_link_up, o_partner_full_duplex,
                            o_partner_speed};
    reg  [15:0] page_d1;
    reg  [15:0] page_d2;
    // Page word two cycles back, lined up with the decoded outputs
    always @(posedge i_clk) begin
        page_d1 <= i_page_word;
        page_d2 <= page_d1;
    end
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);
    // Event sequences: the cycle after must stay free of clears
    sequence s_cfg;
        i_cfg_valid && i_phy_mode && ok ##1 ok;
    endsequence
    sequence s_page;
        i_page_valid && ok ##1 ok;
    endsequence
    sequence s_np;
        i_np_sent && ok ##1 ok;
    endsequence
    // Multi-step relations
    property p_cfg;
        s_cfg |=> o_adv_word == (($past(i_cfg_adv, 2) & 16'hDC00) | 16'h0001);
    endproperty
    property p_clr;
        !ok ##1 (!i_page_valid && !i_np_sent) |=>
            o_np_word == 16'h0001 && dec == 4'h8 && !o_page_received;
    endproperty
    property p_decode;
        s_page |=> dec == {page_d2[15], page_d2[12], page_d2[11:10]};
    endproperty
    // Checks; sequences or ok exclude clears and reconfiguration, except in a_clr_dflt, a_mac_fixed, a_adv_rsvd
    a_mac_fixed: assert property (!i_phy_mode |-> o_adv_word == 16'h0)
        else $error("advertised word not fixed in MAC layout");
    a_adv_rsvd: assert property (i_phy_mode |-> adv_rsvd == 16'h0)
        else $error("reserved advertisement bits set");
    a_cfg_load: assert property (p_cfg)
        else $error("configuration word not advertised");
    a_clr_dflt: assert property (p_clr)
        else $error("defaults not restored after clear");
    a_flag_set: assert property (i_page_valid && ok |=> o_page_received)
        else $error("page received flag not set");
    a_ptn_decode: assert property (p_decode)
        else $error("partner state does not follow page");
    a_ptn_hold: assert property ((!i_page_valid && ok) [*2] |=> $stable(dec))
        else $error("partner state changed without a page");
    a_np_toggle: assert property (s_np |=> $changed(o_np_word[11]))
        else $error("toggle bit did not flip");
endmodule // sga_ability_regs_sva

bind sga_ability_regs sga_ability_regs_sva u_sga_ability_regs_sva (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_clk_locked(i_clk_locked),
    .i_soft_rst(i_soft_rst), .i_phy_mode(i_phy_mode),
    .i_cfg_valid(i_cfg_valid), .i_cfg_adv(i_cfg_adv),
    .i_page_valid(i_page_valid), .i_page_word(i_page_word),
    .i_np_sent(i_np_sent), .o_adv_word(o_adv_word), .o_np_word(o_np_word),
    .o_partner_link_up(o_partner_link_up),
    .o_partner_full_duplex(o_partner_full_duplex),
    .o_partner_speed(o_partner_speed), .o_page_received(o_page_received));

//--- sim/sga_station.sv
// MDIO management station model: makes MDC and shares the data wire.
// Assumes the device samples on MDC rises; the wire has a pull-up.
`timescale 1ns/1ps
`include "sga_defines.vh"
module sga_station (
    // System clock
    input  wire i_clk,
    // Device drive of the data wire
    input  wire i_mdio_out,
    input  wire i_mdio_oe_n,
    // Station side
    output reg  o_mdc,
    output wire o_mdio
);
    reg drive_en;
    reg drive_bit;
    // Wired level; a released party leaves the pull-up in charge
    assign o_mdio = (drive_en ? drive_bit : 1'b1) &
                    (i_mdio_oe_n ? 1'b1 : i_mdio_out);
    // Idle: MDC low, station driving ones
    initial begin
        o_mdc     = 1'b0;
        drive_en  = 1'b1;
        drive_bit = 1'b1;
    end
    // Eight clocks per bit, data changed only at the MDC fall
    task automatic clock_bit(input en, input b, output seen);
        repeat (4) @(posedge i_clk);
        #1;
        o_mdc     = 1'b0;
        drive_en  = en;
        drive_bit = b;
        repeat (4) @(posedge i_clk);
        #1;
        o_mdc = 1'b1;
        seen  = o_mdio;
    endtask
    // Whole frame; a read lets go of the wire from turnaround on
    task automatic frame(input [1:0] op, input [4:0] phy, input [4:0] ra,
                         input [15:0] wdata, output [15:0] rdata);
        reg [31:0] word;
        reg        seen;
        integer    i;
        word  = {2'b01, op, phy, ra, 2'b10, wdata};
        rdata = 16'h0000;
        clock_bit(1'b1, 1'b1, seen);
        for (i = 31; i >= 0; i = i - 1) begin
            clock_bit(op == `SGA_OP_WRITE || i > 17, word[i], seen);
            if (i < 16)
                rdata[i] = seen;
        end
        clock_bit(1'b1, 1'b1, seen);
    endtask
endmodule // sga_station

//--- sim/tb_top.sv
// Self-checking bench for the SGMII ability register bank over MDIO.
// Assumes the station model and the bound checker are compiled with it.
`timescale 1ns/1ps
`include "sga_defines.vh"
module tb_top;
    localparam [4:0] PHY_ADDR = 5'h03;
    reg         i_clk = 1'b0, i_rst_n = 1'b0, i_clk_locked = 1'b1;
    reg         i_soft_rst = 1'b0, i_phy_mode = 1'b1, i_cfg_valid = 1'b0;
    reg         i_page_valid = 1'b0, i_np_sent = 1'b0;
    reg  [15:0] i_cfg_adv = 16'h0000, i_page_word = 16'h0000, w;
    wire        mdc, mdio_wire, mdio_out, mdio_oe_n;
    wire        link_up, full_dup, page_rx;
    wire [1:0]  speed;
    wire [15:0] adv_word, np_word;
    integer     bad_count = 0, samples_checked = 0, i;
    // Device and station
    sga_ability_regs u_sga_ability_regs (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_clk_locked(i_clk_locked),
        .i_soft_rst(i_soft_rst), .i_phy_mode(i_phy_mode),
        .i_phy_addr(PHY_ADDR), .i_cfg_valid(i_cfg_valid),
        .i_cfg_adv(i_cfg_adv), .i_mdc(mdc), .i_mdio_in(mdio_wire),
        .o_mdio_out(mdio_out), .o_mdio_oe_n(mdio_oe_n),
        .i_page_valid(i_page_valid), .i_page_word(i_page_word),
        .i_np_sent(i_np_sent), .o_adv_word(adv_word), .o_np_word(np_word),
        .o_partner_link_up(link_up), .o_partner_full_duplex(full_dup),
        .o_partner_speed(speed), .o_page_received(page_rx));
    sga_station u_sga_station (.i_clk(i_clk), .i_mdio_out(mdio_out),
        .i_mdio_oe_n(mdio_oe_n), .o_mdc(mdc), .o_mdio(mdio_wire));
    // 100 MHz clock
    always #5 i_clk = ~i_clk;
    // Inputs change one nanosecond after the edge
    task tick(input integer n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task check(input [15:0] seen, input [15:0] exp);
        samples_checked = samples_checked + 1;
        if (seen !== exp) begin
            bad_count = bad_count + 1;
            $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task rd_chk(input [4:0] a, input [15:0] exp);
        reg [15:0] d;
        u_sga_station.frame(`SGA_OP_READ, PHY_ADDR, a, 16'hFFFF, d);
        check(d, exp);
    endtask
    task wr(input [4:0] a, input [15:0] d);
        reg [15:0] unused;
        u_sga_station.frame(`SGA_OP_WRITE, PHY_ADDR, a, d, unused);
    endtask
    task page(input [15:0] pw);
        i_page_word  = pw;
        i_page_valid = 1'b1;
        tick(1);
        i_page_valid = 1'b0;
    endtask
    // Mode only changes while reset is held
    task do_reset(input mode);
        i_rst_n    = 1'b0;
        i_phy_mode = mode;
        tick(4);
        i_rst_n = 1'b1;
        tick(2);
    endtask
    task finish_test;
        $display("compares %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Watchdog: about 31 frames of 272 clocks each fit well inside
    initial begin
        #400000;
        bad_count = bad_count + 1;
        finish_test;
    end
    // Test sequence
    initial begin
        do_reset(1'b1);
        rd_chk(`SGA_REG_ADV, 16'h0001);
        rd_chk(`SGA_REG_PARTNER, 16'h8001);
        rd_chk(`SGA_REG_EXPANSION, 16'h0004);
        rd_chk(`SGA_REG_NP_TX, 16'h0001);
        rd_chk(5'h09, 16'h0000);
        $display("test defaults done");
        // Every speed code, with bit 13 set in each write
        for (i = 0; i < 4; i = i + 1) begin
            w = {i[0], ~i[0], 1'b1, i[1], i[1:0], 10'h3FF};
            wr(`SGA_REG_ADV, w);
            rd_chk(`SGA_REG_ADV, (w & 16'hDC00) | 16'h0001);
            check(adv_word, (w & 16'hDC00) | 16'h0001);
        end
        i_cfg_adv   = 16'hFFFF;
        i_cfg_valid = 1'b1;
        tick(1);
        i_cfg_valid = 1'b0;
        rd_chk(`SGA_REG_ADV, 16'hDC01);
        $display("test advertisement done");
        // Partner page, refused writes, flag cleared by its read
        page(16'h7400);
        tick(2);
        check({12'h000, link_up, full_dup, speed}, 16'h0005);
        check({15'h0000, page_rx}, 16'h0001);
        wr(`SGA_REG_PARTNER, 16'hFFFF);
        wr(`SGA_REG_EXPANSION, 16'hFFFF);
        rd_chk(`SGA_REG_PARTNER, 16'h5401);
        rd_chk(`SGA_REG_EXPANSION, 16'h0006);
        rd_chk(`SGA_REG_EXPANSION, 16'h0004);
        $display("test partner done");
        // Next page word reaches the line while reads keep defaults
        wr(`SGA_REG_NP_TX, 16'hFFFF);
        rd_chk(`SGA_REG_NP_TX, 16'h0001);
        check(np_word, 16'hB7FF);
        for (i = 0; i < 2; i = i + 1) begin
            i_np_sent = 1'b1;
            tick(1);
            i_np_sent = 1'b0;
            tick(2);
            check(np_word, i ? 16'hB7FF : 16'hBFFF);
        end
        $display("test next page done");
        // Soft reset, then lost lock, each on dirty state
        for (i = 0; i < 2; i = i + 1) begin
            wr(`SGA_REG_ADV, 16'hFFFF);
            page(16'hFFFF);
            i_soft_rst   = (i == 0);
            i_clk_locked = (i == 0);
            tick(1);
            i_soft_rst   = 1'b0;
            i_clk_locked = 1'b1;
            tick(2);
            check(np_word, 16'h0001);
            rd_chk(`SGA_REG_ADV, 16'h0001);
            rd_chk(`SGA_REG_PARTNER, 16'h8001);
            rd_chk(`SGA_REG_EXPANSION, 16'h0004);
        end
        $display("test clears done");
        // MAC layout ignores writes and the configuration port
        do_reset(1'b0);
        wr(`SGA_REG_ADV, 16'hFFFF);
        i_cfg_valid = 1'b1;
        tick(1);
        i_cfg_valid = 1'b0;
        rd_chk(`SGA_REG_ADV, 16'h0000);
        check(adv_word, 16'h0000);
        $display("test mac layout done");
        finish_test;
    end
endmodule // tb_top

//--- verilog/sga_ability_regs.v
// SGMII auto-negotiation ability registers 4 to 7 behind an MDIO slave:
// local advertisement, partner ability, expansion, next page transmit.
// Assumes the negotiation logic outside presents received pages and
// next-page sent events as one-cycle pulses on i_clk.
//
// Functional notes
// R1 - MAC side: advertisement read-only fixed value
// R2 - PHY side: bit 15 writable link state
// R3 - PHY side: bit 14 writable acknowledge
// R4 - Advertisement bit 13 reads zero, writes dropped
// R5 - Bit 12 duplex, writable local, read-only partner
// R6 - Bits 11:10 speed field, writable, reset 00
// R7 - Partner register read-only, link bit resets one
// R8 - Partner bit 14 read-only acknowledge flag
// R9 - Expansion bit 2 always reads one
// R10 - Page received flag sets, clears on read
// R11 - Next page bit 15 writable, more follow
// R12 - Bits 13, 12 writable message and comply
// R13 - Toggle bit read-only, flips each page sent
// R14 - Code field writable, resets to null code
// R15 - Next page register reads reset values
// R16 - Advertisement also loadable from configuration port
// R17 - Reset, lost lock, soft reset restore defaults
// R18 - Static input picks MAC or PHY layout
`timescale 1ns/1ps
`include "sga_defines.vh"
module sga_ability_regs #(
    parameter NP_SUPPORT = 0  // Nonzero exposes stored next page contents
) (
    // Clock and reset
    input  wire        i_clk,
    input  wire        i_rst_n,
    input  wire        i_clk_locked,
    input  wire        i_soft_rst,
    // Static configuration
    input  wire        i_phy_mode,
    input  wire [4:0]  i_phy_addr,
    // Optional advertisement configuration port
    input  wire        i_cfg_valid,
    input  wire [15:0] i_cfg_adv,
    // MDIO pins
    input  wire        i_mdc,
    input  wire        i_mdio_in,
    output wire        o_mdio_out,
    output wire        o_mdio_oe_n,
    // Line side from the negotiation function
    input  wire        i_page_valid,
    input  wire [15:0] i_page_word,
    input  wire        i_np_sent,
    // Line side to the negotiation function
    output reg  [15:0] o_adv_word,
    output reg  [15:0] o_np_word,
    // Decoded partner state
    output reg         o_partner_link_up,
    output reg         o_partner_full_duplex,
    output reg  [1:0]  o_partner_speed,
    output wire        o_page_received
);

// ------------------------------------------------------------------
// Combined clear
// ------------------------------------------------------------------
// All three sources are synchronous; a lost lock holds the bank cleared
wire       clr_n = i_rst_n & i_clk_locked & ~i_soft_rst; // R17

// ------------------------------------------------------------------
// Storage
// ------------------------------------------------------------------
reg  [15:0] adv_q;
reg  [15:0] partner_q;
reg  [15:0] np_q;
reg         toggle_q;
wire [4:0]  reg_addr;
wire        rd_req;
wire        wr_stb;
wire [15:0] wr_data;
reg  [15:0] rd_data;
wire        page_flag;

// Keeps only the writable ability bits and forces the always-one bit 0
function [15:0] sga_ability;
    input [15:0] word;
    begin
        sga_ability = (word & `SGA_ABIL_MASK) | `SGA_ABIL_ONE;
    end
endfunction

// True when a write strobe targets the given register
function sga_hit;
    input        stb;
    input [4:0]  addr;
    input [4:0]  target;
    begin
        sga_hit = stb & (addr == target);
    end
endfunction

// ------------------------------------------------------------------
// Management frame slave
// ------------------------------------------------------------------
sga_mdio_slave u_mdio (
    .i_clk       (i_clk),
    .i_rst_n     (clr_n),
    .i_mdc       (i_mdc),
    .i_mdio_in   (i_mdio_in),
    .o_mdio_out  (o_mdio_out),
    .o_mdio_oe_n (o_mdio_oe_n),
    .i_phy_addr  (i_phy_addr),
    .o_reg_addr  (reg_addr),
    .o_rd_req    (rd_req),
    .i_rd_data   (rd_data),
    .o_wr_stb    (wr_stb),
    .o_wr_data   (wr_data)
);

// ------------------------------------------------------------------
// Local advertisement
// ------------------------------------------------------------------
// Only bits 15, 14, 12 and 11:10 are stored; bit 13 never lands.
// The configuration port wins over a management write in the same
// cycle, since it is the board-level source of truth.
// Writes are accepted in MAC mode too but stay invisible there.
always @(posedge i_clk) begin
    if (!clr_n)
        adv_q <= `SGA_ADV_RST; // R17
    else if (i_cfg_valid)
        adv_q <= i_cfg_adv & `SGA_ABIL_MASK; // R16
    else if (sga_hit(wr_stb, reg_addr, `SGA_REG_ADV))
        adv_q <= wr_data & `SGA_ABIL_MASK; // R2 R3 R4 R5 R6
end

// ------------------------------------------------------------------
// Partner ability
// ------------------------------------------------------------------
// Loaded only from received pages; management writes are ignored
always @(posedge i_clk) begin
    if (!clr_n)
        partner_q <= `SGA_PARTNER_RST; // R7
    else if (i_page_valid)
        partner_q <= sga_ability(i_page_word); // R7 R8 R5
end

// ------------------------------------------------------------------
// Expansion: page received flag
// ------------------------------------------------------------------
sga_page_flag u_page_flag (
    .i_clk   (i_clk),
    .i_rst_n (clr_n),
    .i_set   (i_page_valid),
    .i_clr   (rd_req & (reg_addr == `SGA_REG_EXPANSION)),
    .o_flag  (page_flag)
);

assign o_page_received = page_flag;

// ------------------------------------------------------------------
// Next page transmit
// ------------------------------------------------------------------
// The toggle is kept apart from the writable word so that a write can
// never disturb the alternation seen by the partner.
always @(posedge i_clk) begin
    if (!clr_n) begin
        np_q     <= `SGA_NP_RST; // R14
        toggle_q <= 1'b0; // R13
    end else begin
        if (sga_hit(wr_stb, reg_addr, `SGA_REG_NP_TX))
            np_q <= wr_data & `SGA_NP_WR_MASK; // R11 R12 R14
        if (i_np_sent)
            toggle_q <= ~toggle_q; // R13
    end
end

// ------------------------------------------------------------------
// Read multiplexer
// ------------------------------------------------------------------
// Undefined addresses read zero. Without next page support the
// transmit register shows its reset word whatever was written.
always @* begin
    rd_data = 16'h0000;
    case (reg_addr)
        `SGA_REG_ADV: begin
            if (i_phy_mode)
                rd_data = sga_ability(adv_q); // R18 R4
            else
                rd_data = `SGA_ADV_MAC_VALUE; // R1
        end
        `SGA_REG_PARTNER:
            rd_data = partner_q; // R7
        `SGA_REG_EXPANSION: begin
            rd_data = `SGA_EXP_FIXED; // R9
            rd_data[`SGA_BIT_PAGE_RX] = page_flag; // R10
        end
        `SGA_REG_NP_TX: begin
            if (NP_SUPPORT != 0) begin
                rd_data = np_q;
                rd_data[`SGA_BIT_NP_TOGGLE] = toggle_q; // R13
            end else begin
                rd_data = `SGA_NP_RST; // R15
            end
        end
        default: rd_data = 16'h0000;
    endcase
end

// ------------------------------------------------------------------
// Line-side words
// ------------------------------------------------------------------
// Registered so the negotiation function sees a clean word per cycle
always @(posedge i_clk) begin
    if (!clr_n) begin
        o_adv_word <= `SGA_ADV_MAC_VALUE;
        o_np_word  <= `SGA_NP_RST;
    end else begin
        if (i_phy_mode)
            o_adv_word <= sga_ability(adv_q); // R18
        else
            o_adv_word <= `SGA_ADV_MAC_VALUE; // R1
        o_np_word <= np_q;
        o_np_word[`SGA_BIT_NP_TOGGLE] <= toggle_q; // R13
    end
end

// ------------------------------------------------------------------
// Decoded partner state
// ------------------------------------------------------------------
// Speed code 11 is passed through; the consumer treats it as invalid
always @(posedge i_clk) begin
    if (!clr_n) begin
        o_partner_link_up     <= 1'b1;
        o_partner_full_duplex <= 1'b0;
        o_partner_speed       <= `SGA_SPD_10M;
    end else begin
        o_partner_link_up     <= partner_q[`SGA_BIT_LINK];
        o_partner_full_duplex <= partner_q[`SGA_BIT_DUPLEX]; // R5
        o_partner_speed       <= partner_q[`SGA_BIT_SPD_HI:
                                           `SGA_BIT_SPD_LO]; // R6
    end
end

endmodule // sga_ability_regs

//--- verilog/sga_defines.vh
// Constants for the SGMII auto-negotiation ability register bank:
// register addresses, bit positions, masks, reset values, MDIO framing.
// Assumes inclusion by bare name from the register bank and MDIO slave sources.
`ifndef SGA_DEFINES_VH
`define SGA_DEFINES_VH

// ------------------------------------------------------------------
// Register addresses on the management interface
// ------------------------------------------------------------------
`define SGA_REG_ADV        5'h04
`define SGA_REG_PARTNER    5'h05
`define SGA_REG_EXPANSION  5'h06
`define SGA_REG_NP_TX      5'h07

// ------------------------------------------------------------------
// Bit positions
// ------------------------------------------------------------------
`define SGA_BIT_LINK       15
`define SGA_BIT_ACK        14
`define SGA_BIT_DUPLEX     12
`define SGA_BIT_SPD_HI     11
`define SGA_BIT_SPD_LO     10
`define SGA_BIT_NP_ABLE    2
`define SGA_BIT_PAGE_RX    1
`define SGA_BIT_NP_MORE    15
`define SGA_BIT_NP_MSG     13
`define SGA_BIT_NP_ACK2    12
`define SGA_BIT_NP_TOGGLE  11

// ------------------------------------------------------------------
// Speed codes
// ------------------------------------------------------------------
`define SGA_SPD_10M        2'h0
`define SGA_SPD_100M       2'h1
`define SGA_SPD_1G         2'h2
`define SGA_SPD_RSVD       2'h3

// ------------------------------------------------------------------
// Masks and reset values
// ------------------------------------------------------------------
`define SGA_ADV_MAC_VALUE  16'h0000
`define SGA_ABIL_MASK      16'hDC00
`define SGA_ABIL_ONE       16'h0001
`define SGA_ADV_RST        16'h0000
`define SGA_PARTNER_RST    16'h8001
`define SGA_EXP_FIXED      16'h0004
`define SGA_NP_WR_MASK     16'hB7FF
`define SGA_NP_RST         16'h0001

// ------------------------------------------------------------------
// MDIO frame
// ------------------------------------------------------------------
`define SGA_OP_WRITE       2'h1
`define SGA_OP_READ        2'h2
`define SGA_HDR_LAST       5'h0C
`define SGA_DATA_LAST      5'h0F
`define SGA_SKIP_LAST      5'h11

`endif

//--- verilog/sga_mdio_slave.v
// MDIO management frame slave: decodes read and write frames for one
// PHY address and turns them into register strobes.
// Assumes MDC is synchronous to i_clk and at most a quarter of its rate.
`timescale 1ns/1ps
`include "sga_defines.vh"
module sga_mdio_slave (
    // Clock and reset
    input  wire        i_clk,
    input  wire        i_rst_n,
    // MDIO pins
    input  wire        i_mdc,
    input  wire        i_mdio_in,
    output reg         o_mdio_out,
    output reg         o_mdio_oe_n,
    input  wire [4:0]  i_phy_addr,
    // Register side
    output reg  [4:0]  o_reg_addr,
    output reg         o_rd_req,
    input  wire [15:0] i_rd_data,
    output reg         o_wr_stb,
    output reg  [15:0] o_wr_data
);

localparam ST_IDLE = 3'h0;
localparam ST_HDR  = 3'h1;
localparam ST_TA   = 3'h2;
localparam ST_RDAT = 3'h3;
localparam ST_WDAT = 3'h4;
localparam ST_SKIP = 3'h5;

reg  [2:0]  state;
reg  [4:0]  cnt;
reg  [15:0] sh;
reg         is_rd;
reg         mdc_q;
wire        mdc_rise = i_mdc & ~mdc_q;
wire [12:0] hdr      = {sh[11:0], i_mdio_in};

// ------------------------------------------------------------------
// Frame sequencer, one step per rising MDC
// ------------------------------------------------------------------
// Preamble is not counted: suppressed preamble is accepted
always @(posedge i_clk) begin
    if (!i_rst_n) begin
        state       <= ST_IDLE;
        cnt         <= 5'h00;
        sh          <= 16'h0000;
        is_rd       <= 1'b0;
        mdc_q       <= 1'b0;
        o_mdio_out  <= 1'b1;
        o_mdio_oe_n <= 1'b1;
        o_reg_addr  <= 5'h00;
        o_rd_req    <= 1'b0;
        o_wr_stb    <= 1'b0;
        o_wr_data   <= 16'h0000;
    end else begin
        mdc_q    <= i_mdc;
        o_rd_req <= 1'b0;
        o_wr_stb <= 1'b0;
        if (o_rd_req)
            sh <= i_rd_data; // Read data lands long before TA ends
        if (mdc_rise) begin
            case (state)
                ST_IDLE: begin
                    if (!i_mdio_in) begin
                        state <= ST_HDR;
                        cnt   <= 5'h00;
                    end
                end
                ST_HDR: begin
                    sh  <= {sh[14:0], i_mdio_in};
                    cnt <= cnt + 5'h01;
                    if (cnt == `SGA_HDR_LAST) begin
                        cnt <= 5'h00;
                        if (hdr[12] && hdr[9:5] == i_phy_addr &&
                            (hdr[11:10] == `SGA_OP_READ ||
                             hdr[11:10] == `SGA_OP_WRITE)) begin
                            state      <= ST_TA;
                            o_reg_addr <= hdr[4:0];
                            is_rd      <= (hdr[11:10] == `SGA_OP_READ);
                            o_rd_req   <= (hdr[11:10] == `SGA_OP_READ);
                        end else begin
                            state <= ST_SKIP;
                        end
                    end
                end
                ST_TA: begin
                    cnt <= 5'h01;
                    if (cnt == 5'h00) begin
                        o_mdio_out  <= 1'b0;
                        o_mdio_oe_n <= ~is_rd;
                    end else begin
                        cnt <= 5'h00;
                        if (is_rd) begin
                            o_mdio_out <= sh[15];
                            sh         <= {sh[14:0], 1'b0};
                            state      <= ST_RDAT;
                        end else begin
                            state <= ST_WDAT;
                        end
                    end
                end
                ST_RDAT: begin
                    cnt <= cnt + 5'h01;
                    if (cnt == `SGA_DATA_LAST) begin
                        o_mdio_out  <= 1'b1;
                        o_mdio_oe_n <= 1'b1;
                        state       <= ST_IDLE;
                    end else begin
                        o_mdio_out <= sh[15];
                        sh         <= {sh[14:0], 1'b0};
                    end
                end
                ST_WDAT: begin
                    sh  <= {sh[14:0], i_mdio_in};
                    cnt <= cnt + 5'h01;
                    if (cnt == `SGA_DATA_LAST) begin
                        o_wr_data <= {sh[14:0], i_mdio_in};
                        o_wr_stb  <= 1'b1;
                        state     <= ST_IDLE;
                    end
                end
                ST_SKIP: begin
                    cnt <= cnt + 5'h01;
                    if (cnt == `SGA_SKIP_LAST)
                        state <= ST_IDLE;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end
end

endmodule // sga_mdio_slave

//--- verilog/sga_page_flag.v
// Sticky event flag: set by hardware, cleared by a read strobe.
// Assumes set and clear are one-cycle pulses on the system clock.
`timescale 1ns/1ps
module sga_page_flag (
    // Clock and reset
    input  wire i_clk,
    input  wire i_rst_n,
    // Events
    input  wire i_set,
    input  wire i_clr,
    // Flag
    output reg  o_flag
);

// ------------------------------------------------------------------
// Flag register
// ------------------------------------------------------------------
// Set wins so a page landing on the clearing read is not lost
always @(posedge i_clk) begin
    if (!i_rst_n)
        o_flag <= 1'b0;
    else if (i_set)
        o_flag <= 1'b1; // R10
    else if (i_clr)
        o_flag <= 1'b0; // R10
end

endmodule // sga_page_flag
